// ### logic/ces_main_end.sv
// Main processor end: coprocessor instruction dialog and exception entry
`timescale 1ns/1ps
module ces_main_end (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Interface register bus
  ces_cir_if.main          cir,
  // Instruction requests
  input  wire logic        go_cmd,
  input  wire logic        go_cond,
  input  wire logic [15:0] cmd_word,
  input  wire logic        go_save,
  input  wire logic        go_restore,
  input  wire logic [15:0] restore_word,
  input  wire logic [31:0] scan_pc,
  // Exception handler return
  input  wire logic        return_from_exception,
  input  wire logic        rte_unmodified,
  // Results
  output logic             busy,
  output logic             done,
  output logic [15:0]      save_word,
  output logic             exc_take,
  output logic [7:0]       exc_vector,
  output logic [3:0]       exc_frame_words,
  output logic [31:0]      exc_scan_pc,
  output logic             resume_at_scan
);
  typedef enum logic [9:0] {
    CES_IDLE  = 10'b0000000001,
    CES_WRCMD = 10'b0000000010,
    CES_RDRSP = 10'b0000000100,
    CES_WRACK = 10'b0000001000,
    CES_WRABT = 10'b0000010000,
    CES_RDSAV = 10'b0000100000,
    CES_WRRST = 10'b0001000000,
    CES_RDRST = 10'b0010000000,
    CES_EXC   = 10'b0100000000,
    CES_RTE   = 10'b1000000000
  } ces_state_t;
  typedef enum logic [5:0] {
    CES_RS_CMD  = 6'b000001,
    CES_RS_RESP = 6'b000010,
    CES_RS_SCAN = 6'b000100,
    CES_RS_SAVE = 6'b001000,
    CES_RS_REST = 6'b010000,
    CES_RS_NONE = 6'b100000
  } ces_restart_t;

  ces_state_t   state;
  ces_restart_t restart;
  logic         is_cond;
  logic [15:0]  cmd_q;
  logic [15:0]  rest_q;
  logic         bus_st;
  logic [4:0]   rtype;

  assign bus_st = (state != CES_IDLE) & (state != CES_EXC) & (state != CES_RTE);
  assign busy   = state != CES_IDLE;
  assign rtype  = cir.cir_rdata[12:8];

  //////////////////////////////////////////////////////////////////////////////
  // Bus cycle launch; no timeout while waiting for acknowledge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cir.cir_strobe <= 1'b0;
      cir.cir_wr     <= 1'b0;
      cir.cir_sel    <= 5'h00;
      cir.cir_wdata  <= 16'h0000;
    end else if (ce) begin
      if (cir.data_size_ack) begin
        cir.cir_strobe <= 1'b0;
      end else if (bus_st & ~cir.cir_strobe) begin
        cir.cir_strobe <= 1'b1;
        case (state)
          CES_WRCMD: begin
            cir.cir_wr    <= 1'b1;
            cir.cir_sel   <= is_cond ? ces_pkg::SEL_COND : ces_pkg::SEL_CMD;
            cir.cir_wdata <= cmd_q;
          end
          CES_WRACK: begin
            cir.cir_wr    <= 1'b1;
            cir.cir_sel   <= ces_pkg::SEL_CTRL;
            cir.cir_wdata <= ces_pkg::CTRL_EXC_ACK;
          end
          CES_WRABT: begin
            cir.cir_wr    <= 1'b1;
            cir.cir_sel   <= ces_pkg::SEL_CTRL;
            cir.cir_wdata <= ces_pkg::CTRL_ABORT;
          end
          CES_WRRST: begin
            cir.cir_wr    <= 1'b1;
            cir.cir_sel   <= ces_pkg::SEL_REST;
            cir.cir_wdata <= rest_q;
          end
          CES_RDSAV: begin
            cir.cir_wr  <= 1'b0;
            cir.cir_sel <= ces_pkg::SEL_SAVE;
          end
          CES_RDRST: begin
            cir.cir_wr  <= 1'b0;
            cir.cir_sel <= ces_pkg::SEL_REST;
          end
          default: begin
            cir.cir_wr  <= 1'b0;
            cir.cir_sel <= ces_pkg::SEL_RESP;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dialog sequencer and exception entry
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state           <= CES_IDLE;
      restart         <= CES_RS_NONE;
      is_cond         <= 1'b0;
      cmd_q           <= 16'h0000;
      rest_q          <= 16'h0000;
      save_word       <= 16'h0000;
      done            <= 1'b0;
      exc_take        <= 1'b0;
      exc_vector      <= 8'h00;
      exc_frame_words <= 4'h0;
      exc_scan_pc     <= 32'h00000000;
      resume_at_scan  <= 1'b0;
    end else if (ce) begin
      done           <= 1'b0;
      exc_take       <= 1'b0;
      resume_at_scan <= 1'b0;
      case (state)
        CES_IDLE: begin
          cmd_q   <= cmd_word;
          rest_q  <= restore_word;
          is_cond <= go_cond;
          if (go_cmd | go_cond) begin
            state <= CES_WRCMD;
          end else if (go_save) begin
            state <= CES_RDSAV;
          end else if (go_restore) begin
            state <= CES_WRRST;
          end
        end
        CES_WRCMD: if (cir.data_size_ack) begin
          state <= CES_RDRSP;
        end
        CES_RDRSP: if (cir.data_size_ack) begin
          exc_vector  <= cir.cir_rdata[7:0];
          exc_scan_pc <= scan_pc;
          if (rtype == ces_pkg::PRIM_PRE) begin
            exc_frame_words <= ces_pkg::FRAME_PRE;
            restart         <= CES_RS_CMD;
            state           <= CES_EXC;
          end else if (rtype == ces_pkg::PRIM_MID) begin
            exc_frame_words <= ces_pkg::FRAME_MID;
            restart         <= CES_RS_RESP;
            state           <= CES_WRACK;
          end else if (rtype == ces_pkg::PRIM_POST) begin
            exc_frame_words <= ces_pkg::FRAME_POST;
            restart         <= CES_RS_SCAN;
            state           <= CES_WRACK;
          end else begin
            done  <= 1'b1;
            state <= CES_IDLE;
          end
        end
        CES_WRACK: if (cir.data_size_ack) begin
          state <= CES_EXC;
        end
        CES_RDSAV: if (cir.data_size_ack) begin
          save_word <= cir.cir_rdata;
          if (cir.cir_rdata == ces_pkg::FMT_INVALID) begin
            restart <= CES_RS_SAVE;
            state   <= CES_WRABT;
          end else begin
            done  <= 1'b1;
            state <= CES_IDLE;
          end
        end
        CES_WRRST: if (cir.data_size_ack) begin
          state <= CES_RDRST;
        end
        CES_RDRST: if (cir.data_size_ack) begin
          if (cir.cir_rdata == ces_pkg::FMT_INVALID) begin
            restart <= CES_RS_REST;
            state   <= CES_WRABT;
          end else begin
            done  <= 1'b1;
            state <= CES_IDLE;
          end
        end
        CES_WRABT: if (cir.data_size_ack) begin
          exc_vector      <= ces_pkg::VEC_FMT;
          exc_frame_words <= ces_pkg::FRAME_PRE;
          state           <= CES_EXC;
        end
        CES_EXC: begin
          exc_take <= 1'b1;
          state    <= CES_RTE;
        end
        CES_RTE: if (return_from_exception) begin
          if (~rte_unmodified) begin
            done  <= 1'b1;
            state <= CES_IDLE;
          end else begin
            case (restart)
              CES_RS_CMD:  state <= CES_WRCMD;
              CES_RS_RESP: state <= CES_RDRSP;
              CES_RS_SAVE: state <= CES_RDSAV;
              CES_RS_REST: state <= CES_WRRST;
              CES_RS_SCAN: begin
                resume_at_scan <= 1'b1;
                state          <= CES_IDLE;
              end
              default:     state <= CES_IDLE;
            endcase
          end
        end
        default: state <= CES_IDLE;
      endcase
    end
  end
endmodule

// ### shared/ces_pkg.sv
// Constants shared by both ends of the coprocessor exception link
package ces_pkg;
  localparam int SEL_W = 5;
  localparam int DAT_W = 16;
  localparam logic [4:0] SEL_RESP   = 5'h00;
  localparam logic [4:0] SEL_CTRL   = 5'h01;
  localparam logic [4:0] SEL_SAVE   = 5'h02;
  localparam logic [4:0] SEL_REST   = 5'h03;
  localparam logic [4:0] SEL_OPW    = 5'h04;
  localparam logic [4:0] SEL_CMD    = 5'h05;
  localparam logic [4:0] SEL_COND   = 5'h07;
  localparam logic [4:0] SEL_OPND   = 5'h08;
  localparam logic [4:0] SEL_REGSEL = 5'h0a;
  localparam logic [4:0] SEL_IADDR  = 5'h0c;
  localparam logic [4:0] SEL_OADDR  = 5'h0e;
  // Primitive type field, bits 12:8
  localparam int PRIM_TYPE_LSB = 8;
  localparam logic [4:0] PRIM_PRE  = 5'h1c;
  localparam logic [4:0] PRIM_MID  = 5'h1d;
  localparam logic [4:0] PRIM_POST = 5'h1e;
  localparam logic [15:0] PRIM_NULL   = 16'h0802;
  localparam logic [15:0] FMT_INVALID = 16'h0100;
  localparam logic [15:0] CTRL_ABORT   = 16'h0001;
  localparam logic [15:0] CTRL_EXC_ACK = 16'h0002;
  localparam logic [7:0] VEC_FLINE = 8'h0b;
  localparam logic [7:0] VEC_PROTO = 8'h0d;
  localparam logic [7:0] VEC_FMT   = 8'h0e;
  localparam logic [3:0] FRAME_PRE  = 4'h4;
  localparam logic [3:0] FRAME_POST = 4'h6;
  localparam logic [3:0] FRAME_MID  = 4'ha;
  // Exception kind codes on the coprocessor user side
  localparam logic [1:0] KIND_PRE  = 2'h0;
  localparam logic [1:0] KIND_MID  = 2'h1;
  localparam logic [1:0] KIND_POST = 2'h2;
endpackage

// ### shared/ces_cir_if.sv
// Interface register bus between main processor and coprocessor
`timescale 1ns/1ps
interface ces_cir_if;
  logic        cir_strobe;
  logic        cir_wr;
  logic [4:0]  cir_sel;
  logic [15:0] cir_wdata;
  logic [15:0] cir_rdata;
  logic        data_size_ack;
  modport main  (output cir_strobe, output cir_wr, output cir_sel, output cir_wdata,
                 input cir_rdata, input data_size_ack);
  modport copro (input cir_strobe, input cir_wr, input cir_sel, input cir_wdata,
                 output cir_rdata, output data_size_ack);
endinterface

// ### logic/ces_copro_end.sv
// Coprocessor end: interface registers and exception reporting
`timescale 1ns/1ps
module ces_copro_end (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Interface register bus
  ces_cir_if.copro         cir,
  // Command path
  input  wire logic        cmd_unknown,
  output logic             cmd_strobe,
  output logic [15:0]      cmd_word,
  output logic [15:0]      operand_word,
  // Internal exceptions
  input  wire logic        dp_exc_req,
  input  wire logic [1:0]  dp_exc_kind,
  input  wire logic [7:0]  dp_exc_vec,
  input  wire logic        bus_err_req,
  input  wire logic [1:0]  bus_err_kind,
  input  wire logic [7:0]  bus_err_vec,
  input  wire logic [15:0] bus_err_info,
  output logic [15:0]      fault_info,
  // Context save and restore
  input  wire logic [15:0] save_fmt_word,
  input  wire logic        save_fmt_bad,
  input  wire logic        restore_fmt_bad,
  output logic             restore_strobe,
  output logic [15:0]      restore_word,
  // Status
  output logic             pv_pending
);
  logic        seen;
  logic        take;
  logic        expect_cmd;
  logic        in_ctx;
  logic        pv_defer;
  logic        pv_read;
  logic        prim_valid;
  logic        prim_read;
  logic [15:0] prim;
  logic [15:0] rest_reg;
  logic        is_sync;
  logic        is_cmd;
  logic        rd_resp;
  logic        wr_ctrl;
  logic        ack_wr;
  logic        abort_wr;
  logic        pv_set;
  logic        pv_clr;
  logic        ev_req;
  logic [1:0]  ev_kind;
  logic [7:0]  ev_vec;
  logic        prim_set;
  logic        prim_clr;
  logic [15:0] resp_val;
  logic [4:0]  ev_type;

  //////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign take     = cir.cir_strobe & ~cir.data_size_ack & ~seen;
  assign is_sync  = (cir.cir_sel == ces_pkg::SEL_OPW) | (cir.cir_sel == ces_pkg::SEL_OPND) |
                    (cir.cir_sel == ces_pkg::SEL_REGSEL) | (cir.cir_sel == ces_pkg::SEL_IADDR) |
                    (cir.cir_sel == ces_pkg::SEL_OADDR);
  assign is_cmd   = take & cir.cir_wr &
                    ((cir.cir_sel == ces_pkg::SEL_CMD) | (cir.cir_sel == ces_pkg::SEL_COND));
  assign rd_resp  = take & ~cir.cir_wr & (cir.cir_sel == ces_pkg::SEL_RESP);
  assign wr_ctrl  = take & cir.cir_wr & (cir.cir_sel == ces_pkg::SEL_CTRL);
  assign ack_wr   = wr_ctrl & ((cir.cir_wdata & ces_pkg::CTRL_EXC_ACK) != 16'h0000);
  assign abort_wr = wr_ctrl & ((cir.cir_wdata & ces_pkg::CTRL_ABORT) != 16'h0000);

  // Violation while a command is expected, or any time inside a context instruction
  assign pv_set = take & is_sync & (expect_cmd | in_ctx);
  // Cleared once the reported primitive was read and then acknowledged
  assign pv_clr = ack_wr & pv_read;

  // Response value: undeferred violation first, then posted primitive, else null release
  always_comb begin
    if (pv_pending & ~pv_defer) begin
      resp_val = {3'h0, ces_pkg::PRIM_MID, ces_pkg::VEC_PROTO};
    end else if (prim_valid) begin
      resp_val = prim;
    end else begin
      resp_val = ces_pkg::PRIM_NULL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event selection for internal and bus exceptions
  assign ev_req  = dp_exc_req | bus_err_req;
  assign ev_kind = bus_err_req ? bus_err_kind : dp_exc_kind;
  assign ev_vec  = bus_err_req ? bus_err_vec : dp_exc_vec;
  always_comb begin
    case (ev_kind)
      ces_pkg::KIND_PRE:  ev_type = ces_pkg::PRIM_PRE;
      ces_pkg::KIND_MID:  ev_type = ces_pkg::PRIM_MID;
      default:            ev_type = ces_pkg::PRIM_POST;
    endcase
  end
  assign prim_clr = (prim_read & ack_wr) | (rd_resp & prim_valid & ~(pv_pending & ~pv_defer) &
                    (prim[12:8] == ces_pkg::PRIM_PRE)) | abort_wr;
  assign prim_set = (ev_req | (is_cmd & cmd_unknown)) & (~prim_valid | prim_clr);

  //////////////////////////////////////////////////////////////////////////////
  // Acknowledge and read data
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cir.data_size_ack <= 1'b0;
      seen              <= 1'b0;
      cir.cir_rdata     <= 16'h0000;
    end else if (ce) begin
      cir.data_size_ack <= take;
      seen              <= cir.cir_strobe & (seen | cir.data_size_ack);
      if (take & ~cir.cir_wr) begin
        case (cir.cir_sel)
          ces_pkg::SEL_RESP: cir.cir_rdata <= resp_val;
          ces_pkg::SEL_SAVE: cir.cir_rdata <= save_fmt_bad ? ces_pkg::FMT_INVALID : save_fmt_word;
          ces_pkg::SEL_REST: cir.cir_rdata <= rest_reg;
          default:           cir.cir_rdata <= 16'h0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Protocol violation tracking
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pv_pending <= 1'b0;
      pv_defer   <= 1'b0;
      pv_read    <= 1'b0;
    end else if (ce) begin
      pv_pending <= pv_set | (pv_pending & ~pv_clr);
      // Held back during a context instruction until the next command
      if (pv_set & in_ctx) begin
        pv_defer <= 1'b1;
      end else if (is_cmd) begin
        pv_defer <= 1'b0;
      end
      if (rd_resp & pv_pending & ~pv_defer) begin
        pv_read <= 1'b1;
      end else if (pv_clr) begin
        pv_read <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dialog state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      expect_cmd <= 1'b1;
      in_ctx     <= 1'b0;
    end else if (ce) begin
      if (abort_wr) begin
        expect_cmd <= 1'b1;
        in_ctx     <= 1'b0;
      end else if (is_cmd) begin
        // Unknown word keeps a command expected; in_ctx clears either way
        expect_cmd <= cmd_unknown;
        in_ctx     <= 1'b0;
      end else if (take & ((~cir.cir_wr & (cir.cir_sel == ces_pkg::SEL_SAVE)) |
                           (cir.cir_wr & (cir.cir_sel == ces_pkg::SEL_REST)))) begin
        in_ctx <= 1'b1;
      end else if (rd_resp & ~pv_pending & ~prim_valid) begin
        expect_cmd <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Posted primitive
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prim_valid <= 1'b0;
      prim_read  <= 1'b0;
      prim       <= 16'h0000;
      fault_info <= 16'h0000;
    end else if (ce) begin
      prim_valid <= prim_set | (prim_valid & ~prim_clr);
      if (prim_set) begin
        if (ev_req) begin
          prim <= {3'h0, ev_type, ev_vec};
        end else begin
          prim <= {3'h0, ces_pkg::PRIM_PRE, ces_pkg::VEC_FLINE};
        end
      end
      if (bus_err_req) begin
        fault_info <= bus_err_info;
      end
      // A primitive cleared by its own read leaves no read mark behind
      if (prim_clr) begin
        prim_read <= 1'b0;
      end else if (rd_resp & prim_valid & ~(pv_pending & ~pv_defer)) begin
        prim_read <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command, operand and restore capture
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd_strobe     <= 1'b0;
      cmd_word       <= 16'h0000;
      operand_word   <= 16'h0000;
      restore_strobe <= 1'b0;
      restore_word   <= 16'h0000;
      rest_reg       <= 16'h0000;
    end else if (ce) begin
      cmd_strobe     <= is_cmd & ~cmd_unknown;
      restore_strobe <= 1'b0;
      if (is_cmd & ~cmd_unknown) begin
        cmd_word <= cir.cir_wdata;
      end
      if (take & cir.cir_wr & (cir.cir_sel == ces_pkg::SEL_OPND)) begin
        operand_word <= cir.cir_wdata;
      end
      if (abort_wr) begin
        rest_reg <= 16'h0000;
      end else if (take & cir.cir_wr & (cir.cir_sel == ces_pkg::SEL_REST)) begin
        restore_strobe <= ~restore_fmt_bad;
        restore_word   <= cir.cir_wdata;
        rest_reg       <= restore_fmt_bad ? ces_pkg::FMT_INVALID : cir.cir_wdata;
      end
    end
  end
endmodule

// ### test/ces_assertions.sv
// Checker for the register bus between the two ends
`timescale 1ns/1ps
module ces_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // Register bus
  input wire logic        cir_strobe,
  input wire logic        cir_wr,
  input wire logic [4:0]  cir_sel,
  input wire logic [15:0] cir_wdata,
  input wire logic [15:0] cir_rdata,
  input wire logic        data_size_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // Control register write that must follow within a few cycles
  sequence s_ctrl_wr(logic [15:0] m);
    ##[1:8] cir_strobe && cir_wr && cir_sel == ces_pkg::SEL_CTRL && cir_wdata == m;
  endsequence
  property p_ack_next;
    $rose(cir_strobe) |=> data_size_ack;
  endproperty
  property p_ack_pulse;
    data_size_ack |=> !data_size_ack;
  endproperty
  property p_req_hold;
    cir_strobe && !data_size_ack |=> cir_strobe && $stable(cir_sel) && $stable(cir_wr) && $stable(cir_wdata);
  endproperty
  property p_req_drop;
    data_size_ack |=> !cir_strobe;
  endproperty
  property p_rdata_read;
    $changed(cir_rdata) |-> data_size_ack && !cir_wr;
  endproperty
  // Response read that returned a primitive of the given type
  sequence s_resp_read(logic [4:0] ty);
    data_size_ack && !cir_wr && cir_sel == ces_pkg::SEL_RESP && cir_rdata[12:8] == ty;
  endsequence
  property p_mid_ack;
    s_resp_read(ces_pkg::PRIM_MID) |-> s_ctrl_wr(ces_pkg::CTRL_EXC_ACK);
  endproperty
  property p_post_ack;
    s_resp_read(ces_pkg::PRIM_POST) |-> s_ctrl_wr(ces_pkg::CTRL_EXC_ACK);
  endproperty
  property p_fmt_abort;
    data_size_ack && !cir_wr && (cir_sel == ces_pkg::SEL_SAVE || cir_sel == ces_pkg::SEL_REST)
      && cir_rdata == ces_pkg::FMT_INVALID |-> s_ctrl_wr(ces_pkg::CTRL_ABORT);
  endproperty
  ////////////////////////////////////////////////////////////////
  a_ack_next: assert property (p_ack_next) else $error("access not acknowledged");
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");
  a_req_hold: assert property (p_req_hold) else $error("request changed before acknowledge");
  a_req_drop: assert property (p_req_drop) else $error("strobe held after acknowledge");
  a_rdata_read: assert property (p_rdata_read) else $error("read data changed outside a read");
  a_mid_ack: assert property (p_mid_ack) else $error("mid primitive not acknowledged");
  a_post_ack: assert property (p_post_ack) else $error("post primitive not acknowledged");
  a_fmt_abort: assert property (p_fmt_abort) else $error("invalid format not aborted");
endmodule

// ### test/testbench.sv
// Testbench joining both ends, plus a second coprocessor driven directly
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, reset, ce, go_cmd, go_cond, go_save, go_restore, return_from_exception, rte_unmodified;
  logic        cmd_unknown, dp_exc_req, bus_err_req, save_fmt_bad, restore_fmt_bad, pv2;
  logic        busy, done, exc_take, resume_at_scan, cmd_strobe, restore_strobe, pv_pending;
  logic [1:0]  dp_exc_kind, bus_err_kind;
  logic [7:0]  dp_exc_vec, bus_err_vec, exc_vector;
  logic [3:0]  exc_frame_words;
  logic [3:0]  fr [3] = '{ces_pkg::FRAME_PRE, ces_pkg::FRAME_MID, ces_pkg::FRAME_POST};
  logic [15:0] cmd_word, restore_word, save_fmt_word, bus_err_info, cw_c, rw_c, rd;
  logic [15:0] save_word, operand_word, fault_info, ow2;
  logic [31:0] scan_pc, exc_scan_pc;
  int          err_total, n_checks, t, n_cs, n_rs;
  ces_cir_if c1();
  ces_cir_if c2();
  ces_main_end ces_main_end_i (.cir(c1.main), .*);
  ces_copro_end ces_copro_end_i (.cir(c1.copro), .cmd_word(cw_c), .restore_word(rw_c), .*);
  ces_copro_end ces_copro_end_i2 (.cir(c2.copro), .cmd_strobe(), .cmd_word(), .operand_word(ow2), .fault_info(),
    .restore_strobe(), .restore_word(), .pv_pending(pv2), .*);
  ces_assertions ces_assertions_i (.sys_clk(sys_clk), .reset(reset), .cir_strobe(c1.cir_strobe),
    .cir_wr(c1.cir_wr), .cir_sel(c1.cir_sel), .cir_wdata(c1.cir_wdata), .cir_rdata(c1.cir_rdata),
    .data_size_ack(c1.data_size_ack));
  // Counts accepted commands and valid restore words
  always @(posedge sys_clk) begin
    n_cs += int'(cmd_strobe);
    n_rs += int'(restore_strobe);
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic start(input logic [3:0] m);
    {go_cmd, go_cond, go_save, go_restore} = m;
    @(posedge sys_clk);
    #1 {go_cmd, go_cond, go_save, go_restore} = 4'h0;
  endtask
  task automatic ret(input logic um);
    {return_from_exception, rte_unmodified} = {1'h1, um};
    @(posedge sys_clk);
    #1 return_from_exception = 1'h0;
  endtask
  // Wait for the end of an instruction and check how it ended
  task automatic wt(input logic [2:0] e, input logic [7:0] v, input logic [3:0] f);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (!(done || exc_take || resume_at_scan) && i < 200);
    if (!(done || exc_take || resume_at_scan)) begin
      err_total++;
      end_of_test();
    end
    chk({resume_at_scan, exc_take, done}, e);
    if (e[1]) begin
      chk(exc_vector, v);
      chk(exc_frame_words, f);
    end
    #1;
  endtask
  // One access on the second register bus
  task automatic bus2(input logic w, input logic [4:0] s, input logic [15:0] d);
    int i;
    {c2.cir_strobe, c2.cir_wr, c2.cir_sel, c2.cir_wdata} = {1'h1, w, s, d};
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (c2.data_size_ack !== 1'h1 && i < 20);
    if (c2.data_size_ack !== 1'h1) begin
      err_total++;
      end_of_test();
    end
    rd = c2.cir_rdata;
    #1 {c2.cir_strobe, c2.cir_wdata} = {1'h0, ~d};
    @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    {go_cmd, go_cond, go_save, go_restore, return_from_exception, rte_unmodified, cmd_unknown, dp_exc_req} = '0;
    {bus_err_req, save_fmt_bad, restore_fmt_bad, dp_exc_kind, bus_err_kind, dp_exc_vec, bus_err_vec} = '0;
    {cmd_word, restore_word, save_fmt_word, bus_err_info, err_total, n_checks, n_cs, n_rs} = '0;
    {c2.cir_strobe, c2.cir_wr, c2.cir_sel, c2.cir_wdata} = '0;
    {ce, reset, scan_pc} = {1'h1, 1'h1, 32'h0000_1000};
    repeat (3) @(posedge sys_clk);
    #1 reset = 1'h0;
    cmd_word = 16'h1234;
    start(4'h8);
    chk(busy, 1'h1);
    wt(3'h1, 8'h00, 4'h0);
    chk(busy, 1'h0);
    chk(cw_c, 16'h1234);
    start(4'h4);
    wt(3'h1, 8'h00, 4'h0);
    $display("end of command test");
    cmd_unknown = 1'h1;
    start(4'h8);
    wt(3'h2, ces_pkg::VEC_FLINE, ces_pkg::FRAME_PRE);
    cmd_unknown = 1'h0;
    ret(1'h1);
    wt(3'h1, 8'h00, 4'h0);
    $display("end of unknown command test");
    for (t = 0; t < 3; t++) begin
      {dp_exc_req, dp_exc_kind, dp_exc_vec} = {1'h1, 2'(t), 8'h30 + 8'(t)};
      @(posedge sys_clk);
      #1 dp_exc_req = 1'h0;
      start(4'h8);
      wt(3'h2, 8'h30 + 8'(t), fr[t]);
      chk(exc_scan_pc, 32'h0000_1000);
      ret(1'h1);
      wt(t == 2 ? 3'h4 : 3'h1, 8'h00, 4'h0);
    end
    $display("end of primitive kind test");
    {bus_err_req, bus_err_kind, bus_err_vec, bus_err_info} = {1'h1, 2'h1, 8'h40, 16'hbeef};
    {dp_exc_req, dp_exc_vec} = {1'h1, 8'h55};
    @(posedge sys_clk);
    #1 {bus_err_req, dp_exc_req} = 2'h0;
    chk(fault_info, 16'hbeef);
    start(4'h8);
    wt(3'h2, 8'h40, ces_pkg::FRAME_MID);
    ret(1'h0);
    wt(3'h1, 8'h00, 4'h0);
    $display("end of bus error test");
    {save_fmt_bad, save_fmt_word} = {1'h1, 16'h2a00};
    start(4'h2);
    wt(3'h2, ces_pkg::VEC_FMT, ces_pkg::FRAME_PRE);
    save_fmt_bad = 1'h0;
    ret(1'h1);
    wt(3'h1, 8'h00, 4'h0);
    chk(save_word, 16'h2a00);
    {restore_fmt_bad, restore_word} = {1'h1, 16'h2b00};
    start(4'h1);
    wt(3'h2, ces_pkg::VEC_FMT, ces_pkg::FRAME_PRE);
    restore_fmt_bad = 1'h0;
    ret(1'h1);
    wt(3'h1, 8'h00, 4'h0);
    chk(rw_c, 16'h2b00);
    chk(n_cs, 8);
    chk(n_rs, 1);
    $display("end of format error test");
    bus2(1'h0, ces_pkg::SEL_RESP, 16'h0000);
    chk(rd, 16'h1c30);
    chk(pv2, 1'h0);
    bus2(1'h1, ces_pkg::SEL_OPND, 16'h0005);
    chk(ow2, 16'h0005);
    bus2(1'h0, ces_pkg::SEL_RESP, 16'h0000);
    chk(rd, 16'h1d0d);
    chk(pv2, 1'h1);
    bus2(1'h1, ces_pkg::SEL_CTRL, ces_pkg::CTRL_EXC_ACK);
    chk(pv2, 1'h0);
    bus2(1'h0, ces_pkg::SEL_SAVE, 16'h0000);
    chk(rd, 16'h2a00);
    bus2(1'h1, ces_pkg::SEL_OPND, 16'h0006);
    bus2(1'h0, ces_pkg::SEL_RESP, 16'h0000);
    chk(rd, ces_pkg::PRIM_NULL);
    bus2(1'h1, ces_pkg::SEL_CMD, 16'h1234);
    bus2(1'h0, ces_pkg::SEL_RESP, 16'h0000);
    chk(rd, 16'h1d0d);
    $display("end of violation test");
    end_of_test();
  end
endmodule
